// file: pkg/cid_pkg.sv
package cid_pkg;
	// ---------------------------------------------------------------
	// widths and values after reset
	// ---------------------------------------------------------------
	localparam int          PC_W      = 13;
	localparam logic [12:0] PC_RESET  = 13'h0000;
	localparam logic [4:0]  CCR_RESET = 5'h08;
	localparam int          CC_C      = 0;
	localparam int          CC_Z      = 1;
	localparam int          CC_N      = 2;
	localparam int          CC_I      = 3;
	localparam int          CC_H      = 4;

	// ---------------------------------------------------------------
	// opcode rows (high nibble): class and addressing mode
	// ---------------------------------------------------------------
	localparam logic [3:0] ROW_BRBIT   = 4'h0;
	localparam logic [3:0] ROW_BITSC   = 4'h1;
	localparam logic [3:0] ROW_BRANCH  = 4'h2;
	localparam logic [3:0] ROW_RMW_DIR = 4'h3;
	localparam logic [3:0] ROW_RMW_A   = 4'h4;
	localparam logic [3:0] ROW_RMW_X   = 4'h5;
	localparam logic [3:0] ROW_RMW_IX1 = 4'h6;
	localparam logic [3:0] ROW_RMW_IX  = 4'h7;
	localparam logic [3:0] ROW_CTRL    = 4'h9;
	localparam logic [3:0] ROW_IMM     = 4'hA;
	localparam logic [3:0] ROW_DIR     = 4'hB;
	localparam logic [3:0] ROW_EXT     = 4'hC;
	localparam logic [3:0] ROW_IX2     = 4'hD;
	localparam logic [3:0] ROW_IX1     = 4'hE;
	localparam logic [3:0] ROW_IX      = 4'hF;

	// ---------------------------------------------------------------
	// function nibbles
	// ---------------------------------------------------------------
	localparam logic [3:0] FN_SUB = 4'h0;
	localparam logic [3:0] FN_CMP = 4'h1;
	localparam logic [3:0] FN_SBC = 4'h2;
	localparam logic [3:0] FN_CPX = 4'h3;
	localparam logic [3:0] FN_AND = 4'h4;
	localparam logic [3:0] FN_BIT = 4'h5;
	localparam logic [3:0] FN_STA = 4'h7;
	localparam logic [3:0] FN_EOR = 4'h8;
	localparam logic [3:0] FN_ADC = 4'h9;
	localparam logic [3:0] FN_ORA = 4'hA;
	localparam logic [3:0] FN_ADD = 4'hB;
	localparam logic [3:0] FN_JMP = 4'hC;
	localparam logic [3:0] FN_JSR = 4'hD;
	localparam logic [3:0] FN_LDX = 4'hE;
	localparam logic [3:0] FN_STX = 4'hF;
	localparam logic [3:0] RMW_NEG = 4'h0;
	localparam logic [3:0] RMW_COM = 4'h3;
	localparam logic [3:0] RMW_LSR = 4'h4;
	localparam logic [3:0] RMW_ROR = 4'h6;
	localparam logic [3:0] RMW_ASR = 4'h7;
	localparam logic [3:0] RMW_LSL = 4'h8;
	localparam logic [3:0] RMW_ROL = 4'h9;
	localparam logic [3:0] RMW_DEC = 4'hA;
	localparam logic [3:0] RMW_INC = 4'hC;
	localparam logic [3:0] RMW_TST = 4'hD;
	localparam logic [3:0] RMW_CLR = 4'hF;
	localparam logic [3:0] CTL_TAX = 4'h7;
	localparam logic [3:0] CTL_CLC = 4'h8;
	localparam logic [3:0] CTL_SEC = 4'h9;
	localparam logic [3:0] CTL_CLI = 4'hA;
	localparam logic [3:0] CTL_SEI = 4'hB;
	localparam logic [3:0] CTL_TXA = 4'hF;
	localparam logic [7:0] OP_MUL  = 8'h42;
	localparam logic [7:0] OP_BSR  = 8'hAD;

	typedef enum logic [2:0] {
		S_FETCH, S_OPND, S_ADDR, S_READ, S_EXEC, S_WRITE
	} cid_state_e;

	typedef enum logic [2:0] {
		CL_REGMEM, CL_RMW, CL_BRANCH, CL_BIT, CL_CTRL
	} cid_class_e;

	// ---------------------------------------------------------------
	// opcode decode used by the core
	// ---------------------------------------------------------------
	function automatic logic [1:0] opnd_bytes(input logic [7:0] o);
		case (o[7:4])
		ROW_BRBIT, ROW_EXT, ROW_IX2: opnd_bytes = 2'd2;
		ROW_BITSC, ROW_BRANCH, ROW_RMW_DIR, ROW_RMW_IX1,
		ROW_IMM, ROW_DIR, ROW_IX1: opnd_bytes = 2'd1;
		default: opnd_bytes = 2'd0;
		endcase
	endfunction : opnd_bytes

	function automatic cid_class_e classify(input logic [7:0] o);
		case (o[7:4])
		ROW_BRBIT, ROW_BITSC: classify = CL_BIT;
		ROW_BRANCH: classify = CL_BRANCH;
		ROW_RMW_DIR, ROW_RMW_A, ROW_RMW_X, ROW_RMW_IX1, ROW_RMW_IX:
			classify = CL_RMW;
		ROW_IMM: begin
			if (o == OP_BSR)
				classify = CL_BRANCH;
			else if (o[3:0] == FN_STA || o[3:0] == FN_STX ||
				o[3:0] == FN_JMP || o[3:0] == FN_JSR)
				classify = CL_CTRL; // no immediate form, runs as no-op
			else
				classify = CL_REGMEM;
		end
		ROW_DIR, ROW_EXT, ROW_IX2, ROW_IX1, ROW_IX:
			classify = CL_REGMEM;
		default: classify = CL_CTRL;
		endcase
	endfunction : classify

	// stores and jumps need only the address, not the data behind it
	function automatic logic reads_mem(input logic [7:0] o);
		case (o[7:4])
		ROW_BRBIT, ROW_BITSC, ROW_RMW_DIR, ROW_RMW_IX1, ROW_RMW_IX:
			reads_mem = 1'b1;
		ROW_DIR, ROW_EXT, ROW_IX2, ROW_IX1, ROW_IX:
			reads_mem = !(o[3:0] == FN_STA || o[3:0] == FN_STX ||
				o[3:0] == FN_JMP || o[3:0] == FN_JSR);
		default: reads_mem = 1'b0;
		endcase
	endfunction : reads_mem

	function automatic logic [12:0] ea_of(input logic [3:0] r,
		input logic [7:0] a1, input logic [7:0] a2, input logic [7:0] x);
		case (r)
		ROW_BRBIT, ROW_BITSC, ROW_RMW_DIR, ROW_DIR:
			ea_of = {5'h00, a1};
		ROW_EXT: ea_of = {a1[4:0], a2};
		ROW_IX2: ea_of = {a1[4:0], a2} + {5'h00, x};
		ROW_RMW_IX1, ROW_IX1:
			ea_of = {5'h00, a1} + {5'h00, x};
		ROW_RMW_IX, ROW_IX: ea_of = {5'h00, x};
		default: ea_of = 13'h0000;
		endcase
	endfunction : ea_of
endpackage : cid_pkg

// file: src/cid_alu.sv
`timescale 1ns/1ps
`default_nettype none
module cid_alu
	import cid_pkg::*;
(
	input  wire logic       rmw_in,
	input  wire logic [3:0] fn_in,
	input  wire logic [7:0] a_in,
	input  wire logic [7:0] m_in,
	input  wire logic       c_in,
	output logic      [7:0] res_out,
	output logic            c_out,
	output logic            h_out,
	output logic            c_upd_out,
	output logic            h_upd_out
);
	logic       cy;
	logic [8:0] sum;
	logic [4:0] hsum;
	logic [8:0] dif;

	always_comb begin
		cy = c_in & ~rmw_in & ((fn_in == FN_ADC) | (fn_in == FN_SBC));
		sum = {1'b0, a_in} + {1'b0, m_in} + {8'h00, cy};
		hsum = {1'b0, a_in[3:0]} + {1'b0, m_in[3:0]} + {4'h0, cy};
		dif = {1'b0, a_in} - {1'b0, m_in} - {8'h00, cy};
		res_out = m_in;
		c_out = c_in;
		h_out = 1'b0;
		c_upd_out = 1'b0;
		h_upd_out = 1'b0;
		if (rmw_in) begin
			case (fn_in)
			RMW_NEG: begin
				res_out = 8'h00 - m_in;
				c_out = |m_in;
				c_upd_out = 1'b1;
			end
			RMW_COM: begin
				res_out = ~m_in;
				c_out = 1'b1;
				c_upd_out = 1'b1;
			end
			RMW_LSR: begin
				res_out = {1'b0, m_in[7:1]};
				c_out = m_in[0];
				c_upd_out = 1'b1;
			end
			RMW_ROR: begin
				res_out = {c_in, m_in[7:1]};
				c_out = m_in[0];
				c_upd_out = 1'b1;
			end
			RMW_ASR: begin
				res_out = {m_in[7], m_in[7:1]};
				c_out = m_in[0];
				c_upd_out = 1'b1;
			end
			RMW_LSL: begin
				res_out = {m_in[6:0], 1'b0};
				c_out = m_in[7];
				c_upd_out = 1'b1;
			end
			RMW_ROL: begin
				res_out = {m_in[6:0], c_in};
				c_out = m_in[7];
				c_upd_out = 1'b1;
			end
			RMW_DEC: res_out = m_in - 8'h01;
			RMW_INC: res_out = m_in + 8'h01;
			RMW_CLR: res_out = 8'h00;
			default: res_out = m_in;
			endcase
		end else begin
			case (fn_in)
			FN_SUB, FN_CMP, FN_SBC, FN_CPX: begin
				res_out = dif[7:0];
				c_out = dif[8];
				c_upd_out = 1'b1;
			end
			FN_AND, FN_BIT: res_out = a_in & m_in;
			FN_EOR: res_out = a_in ^ m_in;
			FN_ORA: res_out = a_in | m_in;
			FN_ADD, FN_ADC: begin
				res_out = sum[7:0];
				c_out = sum[8];
				h_out = hsum[4];
				c_upd_out = 1'b1;
				h_upd_out = 1'b1;
			end
			FN_STA, FN_STX: res_out = a_in;
			default: res_out = m_in;
			endcase
		end
	end
endmodule : cid_alu
`default_nettype wire

// file: src/cid_core.sv
// Summary of operation
// - carry flag follows ALU carry/borrow, shifts, rotates, bit tests
// - opcodes decode into five classes covering the basic operations
// - register/memory ops pair A or X with memory; jumps take no register
// - read-modify-write writes the result back; test op only sets flags
// - conditional branches are two bytes; false condition just moves on
// - branches on interrupt line low/high and on mask clear/set
// - bit set and clear reach the lowest 256 bytes as RMW; bit test only reads
// - tested bit is copied to carry whether or not the branch is taken
// - ten addressing modes form the effective address from the opcode
// - immediate operand is the byte after the opcode
// - direct mode: one address byte reaches the lowest 256 bytes
// - extended mode: two address bytes reach all memory
// - relative offset is signed and added only when condition holds
// - indexed without offset: address equals the index register
// - indexed 8-bit offset: unsigned index plus byte, up to 510
// - indexed 16-bit offset: unsigned index plus two-byte offset
// - bit set/clear: bit number in opcode, direct address in byte two
// - bit branch: bit and polarity in opcode, address, signed offset
// - program counter is 13 bits, address of next byte to fetch
// - half carry set by add ops on a carry from bit 3 to bit 4
`timescale 1ns/1ps
`default_nettype none
module cid_core
	import cid_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic [7:0]  mem_rdata_in,
	input  wire logic        irq_line_in,
	output logic      [12:0] mem_addr_out,
	output logic             mem_rd_out,
	output logic             mem_wr_out,
	output logic      [7:0]  mem_wdata_out,
	output logic      [12:0] program_counter_out,
	output logic      [7:0]  acc_out,
	output logic      [7:0]  index_out,
	output logic      [4:0]  condition_code_out,
	output logic      [12:0] effective_addr_out,
	output logic      [2:0]  instr_class_out,
	output logic             instr_done_out
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	cid_state_e  state, next_state;
	cid_class_e  cls, next_cls;
	logic [PC_W-1:0] pc, next_pc;
	logic [12:0] ea, next_ea, maddr, next_maddr, ea_calc, pc_rel;
	logic [7:0]  acc, next_acc, idx, next_idx, op, next_op;
	logic [7:0]  b1, next_b1, b2, next_b2, opnd, next_opnd;
	logic [7:0]  mwd, next_mwd, rel_byte, bmask, alu_a, alu_res, conds;
	logic [4:0]  condition_code_reg, next_ccr;
	logic [1:0]  nleft, next_nleft;
	logic        first, next_first, mrd, next_mrd, mwr, next_mwr;
	logic        done, next_done, need_read, bit_val, br_base, br_taken;
	logic        alu_c, alu_h, alu_cu, alu_hu;
	logic [3:0]  row, fn;

	assign row = op[7:4];
	assign fn  = op[3:0];

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	always_comb begin
		ea_calc = ea_of(row, b1, b2, idx);
		need_read = reads_mem(op);
		conds = {!irq_line_in, !condition_code_reg[CC_I], !condition_code_reg[CC_N], !condition_code_reg[CC_H],
			!condition_code_reg[CC_Z], !condition_code_reg[CC_C], !(condition_code_reg[CC_C] | condition_code_reg[CC_Z]), 1'b1};
		br_base = conds[op[3:1]];
		bit_val = opnd[op[3:1]];
		bmask = 8'h01 << op[3:1];
		if (op == OP_BSR)
			br_taken = 1'b1;
		else if (row == ROW_BRBIT)
			br_taken = bit_val ^ op[0];
		else
			br_taken = br_base ^ op[0];
		// offset is relative to the already advanced counter
		rel_byte = (row == ROW_BRBIT) ? b2 : b1;
		pc_rel = pc + {{5{rel_byte[7]}}, rel_byte};
		alu_a = (fn == FN_CPX || fn == FN_STX) ? idx : acc;
	end

	cid_alu u_alu (
		.rmw_in   (cls == CL_RMW),
		.fn_in    (fn),
		.a_in     (alu_a),
		.m_in     (opnd),
		.c_in     (condition_code_reg[CC_C]),
		.res_out  (alu_res),
		.c_out    (alu_c),
		.h_out    (alu_h),
		.c_upd_out(alu_cu),
		.h_upd_out(alu_hu)
	);

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_cls = cls;
		next_pc = pc;
		next_ea = ea;
		next_maddr = maddr;
		next_acc = acc;
		next_idx = idx;
		next_op = op;
		next_b1 = b1;
		next_b2 = b2;
		next_opnd = opnd;
		next_mwd = mwd;
		next_ccr = condition_code_reg;
		next_nleft = nleft;
		next_first = first;
		next_mrd = 1'b0;
		next_mwr = 1'b0;
		next_done = 1'b0;
		case (state)
		S_FETCH: begin
			next_op = mem_rdata_in;
			next_cls = classify(mem_rdata_in);
			next_pc = pc + 13'h0001;
			next_maddr = pc + 13'h0001;
			next_nleft = opnd_bytes(mem_rdata_in);
			next_first = 1'b1;
			if (opnd_bytes(mem_rdata_in) != 2'd0) begin
				next_state = S_OPND;
				next_mrd = 1'b1;
			end else
				next_state = S_ADDR;
		end
		S_OPND: begin
			if (first)
				next_b1 = mem_rdata_in;
			else
				next_b2 = mem_rdata_in;
			next_first = 1'b0;
			next_pc = pc + 13'h0001;
			next_maddr = pc + 13'h0001;
			next_nleft = nleft - 2'd1;
			if (nleft == 2'd1)
				next_state = S_ADDR;
			else
				next_mrd = 1'b1;
		end
		S_ADDR: begin
			next_ea = ea_calc;
			next_maddr = ea_calc;
			if (row == ROW_IMM)
				next_opnd = b1;
			else if (row == ROW_RMW_A)
				next_opnd = acc;
			else if (row == ROW_RMW_X)
				next_opnd = idx;
			if (need_read) begin
				next_state = S_READ;
				next_mrd = 1'b1;
			end else
				next_state = S_EXEC;
		end
		S_READ: begin
			next_opnd = mem_rdata_in;
			next_state = S_EXEC;
		end
		S_EXEC: begin
			case (cls)
			CL_BIT: begin
				if (!op[4]) begin
					next_ccr[CC_C] = bit_val;
					if (br_taken)
						next_pc = pc_rel;
				end else begin
					next_mwd = op[0] ? (opnd & ~bmask)
						: (opnd | bmask);
					next_mwr = 1'b1;
				end
			end
			CL_BRANCH: begin
				if (br_taken)
					next_pc = pc_rel;
			end
			CL_RMW: begin
				if (op == OP_MUL) begin
					{next_idx, next_acc} = 16'(idx) * 16'(acc);
					next_ccr[CC_H] = 1'b0;
					next_ccr[CC_C] = 1'b0;
				end else begin
					next_ccr[CC_N] = alu_res[7];
					next_ccr[CC_Z] = (alu_res == 8'h00);
					if (alu_cu)
						next_ccr[CC_C] = alu_c;
					if (fn != RMW_TST) begin
						if (row == ROW_RMW_A)
							next_acc = alu_res;
						else if (row == ROW_RMW_X)
							next_idx = alu_res;
						else begin
							next_mwd = alu_res;
							next_mwr = 1'b1;
						end
					end
				end
			end
			CL_REGMEM: begin
				if (fn == FN_JMP || fn == FN_JSR)
					next_pc = ea;
				else begin
					next_ccr[CC_N] = alu_res[7];
					next_ccr[CC_Z] = (alu_res == 8'h00);
					if (alu_cu)
						next_ccr[CC_C] = alu_c;
					if (alu_hu)
						next_ccr[CC_H] = alu_h;
					if (fn == FN_STA || fn == FN_STX) begin
						next_mwd = alu_res;
						next_mwr = 1'b1;
					end else if (fn == FN_LDX)
						next_idx = alu_res;
					else if (fn != FN_CMP && fn != FN_CPX &&
						fn != FN_BIT)
						next_acc = alu_res;
				end
			end
			default: begin
				case ((row == ROW_CTRL) ? fn : 4'h0) // other rows: no-op
				CTL_TAX: next_idx = acc;
				CTL_TXA: next_acc = idx;
				CTL_CLC: next_ccr[CC_C] = 1'b0;
				CTL_SEC: next_ccr[CC_C] = 1'b1;
				CTL_CLI: next_ccr[CC_I] = 1'b0;
				CTL_SEI: next_ccr[CC_I] = 1'b1;
				default: next_ccr = condition_code_reg;
				endcase
			end
			endcase
			if (next_mwr) begin
				next_maddr = ea;
				next_state = S_WRITE;
			end else begin
				next_maddr = next_pc;
				next_mrd = 1'b1;
				next_done = 1'b1;
				next_state = S_FETCH;
			end
		end
		S_WRITE: begin
			next_maddr = pc;
			next_mrd = 1'b1;
			next_done = 1'b1;
			next_state = S_FETCH;
		end
		default: next_state = S_FETCH;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state <= S_FETCH;
			cls <= CL_CTRL;
			pc <= PC_RESET;
			ea <= 13'h0000;
			maddr <= PC_RESET;
			acc <= 8'h00;
			idx <= 8'h00;
			op <= 8'h00;
			b1 <= 8'h00;
			b2 <= 8'h00;
			opnd <= 8'h00;
			mwd <= 8'h00;
			condition_code_reg <= CCR_RESET;
			nleft <= 2'd0;
			first <= 1'b0;
			mrd <= 1'b1;
			mwr <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			cls <= next_cls;
			pc <= next_pc;
			ea <= next_ea;
			maddr <= next_maddr;
			acc <= next_acc;
			idx <= next_idx;
			op <= next_op;
			b1 <= next_b1;
			b2 <= next_b2;
			opnd <= next_opnd;
			mwd <= next_mwd;
			condition_code_reg <= next_ccr;
			nleft <= next_nleft;
			first <= next_first;
			mrd <= next_mrd;
			mwr <= next_mwr;
			done <= next_done;
		end
	end

	assign mem_addr_out        = maddr;
	assign mem_rd_out          = mrd;
	assign mem_wr_out          = mwr;
	assign mem_wdata_out       = mwd;
	assign program_counter_out = pc;
	assign acc_out             = acc;
	assign index_out           = idx;
	assign condition_code_out  = condition_code_reg;
	assign effective_addr_out  = ea;
	assign instr_class_out     = cls;
	assign instr_done_out      = done;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	a_bit_carry: assert property ((state == S_EXEC && cls == CL_BIT && !op[4])
		|=> condition_code_reg[CC_C] == $past(bit_val)) else $error("carry not bit");
	a_tst_nowrite: assert property ((state == S_EXEC && cls == CL_RMW &&
		fn == RMW_TST) |=> !mwr && done) else $error("test wrote");
	a_br_false: assert property ((state == S_EXEC && cls == CL_BRANCH &&
		!br_taken) |=> pc == $past(pc)) else $error("untaken moved");
	a_br_taken: assert property ((state == S_EXEC && cls == CL_BRANCH &&
		br_taken) |=> pc == $past(pc_rel)) else $error("bad target");
	a_ix1_sum: assert property ((state == S_ADDR && row == ROW_IX1) |=>
		ea == 13'($past(b1)) + 13'($past(idx))) else $error("ix1 ea");
	a_dir_low: assert property ((state == S_ADDR && row == ROW_DIR) |=>
		ea[12:8] == 5'h00) else $error("direct above 255");
	a_bitsc_write: assert property ((state == S_EXEC && cls == CL_BIT && op[4])
		|=> mwr && maddr[12:8] == 5'h00 ##1 done) else $error("bsc");
	a_done_fetch: assert property (done |-> state == S_FETCH && mrd &&
		maddr == pc) else $error("fetch not at counter");
endmodule : cid_core
`default_nettype wire

// file: verification/cid_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cid_mem_model
	import cid_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic [12:0] addr_in,
	input  wire logic        rd_in,
	input  wire logic        wr_in,
	input  wire logic [7:0]  wdata_in,
	output logic      [7:0]  rdata_out
);
	// ---------------------------------------------------------------
	// asynchronous-read byte store
	// ---------------------------------------------------------------
	logic [7:0] mem [0:8191];
	logic [7:0] last = 8'h5A;

	// plain always: the bench preloads mem by hierarchical writes
	always @(posedge mclk_in) begin
		if (wr_in)
			mem[addr_in] <= wdata_in;
		if (rd_in)
			last <= mem[addr_in];
	end

	// idle bus shows inverted last byte so stale data cannot pass
	assign rdata_out = rd_in ? mem[addr_in] : ~last;
endmodule : cid_mem_model
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
	n_mismatch++; $display("ERROR %s exp %h got %h", nm, ex, got); end end
module testbench
	import cid_pkg::*;
;
	logic        mclk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        irq_line_in = 1'b1;
	logic [7:0]  rdata;
	logic [12:0] mem_addr_out;
	logic        mem_rd_out;
	logic        mem_wr_out;
	logic [7:0]  mem_wdata_out;
	logic [7:0]  acc_out;
	logic [7:0]  index_out;
	logic [12:0] program_counter_out;
	logic [2:0]  instr_class_out;
	logic [4:0]  condition_code_out;
	logic [12:0] effective_addr_out;
	logic        instr_done_out;
	int          n_mismatch = 0;
	int          comparisons = 0;
	int          n_wr = 0;

	always #2.5 mclk_in = ~mclk_in;

	cid_core dut_u (
		.mclk_in            (mclk_in),
		.rst_in             (rst_in),
		.mem_rdata_in       (rdata),
		.irq_line_in        (irq_line_in),
		.mem_addr_out       (mem_addr_out),
		.mem_rd_out         (mem_rd_out),
		.mem_wr_out         (mem_wr_out),
		.mem_wdata_out      (mem_wdata_out),
		.program_counter_out(program_counter_out),
		.acc_out            (acc_out),
		.index_out          (index_out),
		.condition_code_out (condition_code_out),
		.effective_addr_out (effective_addr_out),
		.instr_class_out    (instr_class_out),
		.instr_done_out     (instr_done_out)
	);

	cid_mem_model mem_u (
		.mclk_in  (mclk_in),
		.addr_in  (mem_addr_out),
		.rd_in    (mem_rd_out),
		.wr_in    (mem_wr_out),
		.wdata_in (mem_wdata_out),
		.rdata_out(rdata)
	);

	always @(posedge mclk_in)
		if (mem_wr_out === 1'b1)
			n_wr++;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_sim

	task automatic prog(input logic [12:0] a, input logic [7:0] b[$]);
		foreach (b[i])
			mem_u.mem[a + 13'(i)] = b[i];
	endtask : prog

	// program must be loaded first: the opcode is fetched at release
	task automatic start();
		@(posedge mclk_in);
		#1 rst_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		#1 rst_in = 1'b0;
	endtask : start

	// run one instruction; the next opcode fetch address is checked
	task automatic step(input logic [12:0] nxt);
		int i;
		i = 0;
		do begin
			@(posedge mclk_in);
			#1 i++;
		end while (instr_done_out !== 1'b1 && i < 100);
		if (i >= 100) begin
			n_mismatch++;
			$display("ERROR done timeout");
			end_sim();
		end
		`CHK("next_fetch", nxt, mem_addr_out)
		`CHK("pc", nxt, program_counter_out)
	endtask : step

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_arith();
		prog(13'h000, '{8'hA6, 8'h0F, 8'hAB, 8'h01, 8'hAB, 8'hF0,
			8'hA6, 8'h81, 8'h48, 8'h46});
		start();
		step(13'h002);
		`CHK("acc_imm", 8'h0F, acc_out)
		step(13'h004);
		`CHK("half", 1'b1, condition_code_out[CC_H])
		`CHK("carry0", 1'b0, condition_code_out[CC_C])
		step(13'h006);
		`CHK("sum", 8'h00, acc_out)
		`CHK("carry1", 1'b1, condition_code_out[CC_C])
		`CHK("half0", 1'b0, condition_code_out[CC_H])
		step(13'h008);
		step(13'h009);
		`CHK("cls_rmw", CL_RMW, instr_class_out)
		`CHK("shl", 8'h02, acc_out)
		`CHK("shl_c", 1'b1, condition_code_out[CC_C])
		step(13'h00A);
		`CHK("ror", 8'h81, acc_out)
		`CHK("ror_c", 1'b0, condition_code_out[CC_C])
		$display("test arith done");
	endtask : t_arith

	task automatic t_modes();
		prog(13'h000, '{8'hAE, 8'hFF, 8'hE6, 8'hFF, 8'hF6, 8'hB6, 8'h40,
			8'hC6, 8'h12, 8'h34, 8'hD6, 8'h10, 8'h00});
		prog(13'h1FE, '{8'h11});
		prog(13'h0FF, '{8'h22});
		prog(13'h040, '{8'h33});
		prog(13'h1234, '{8'h44});
		prog(13'h10FF, '{8'h55});
		start();
		step(13'h002);
		`CHK("cls_regmem", CL_REGMEM, instr_class_out)
		step(13'h004);
		`CHK("ea_ix1", 13'h1FE, effective_addr_out)
		`CHK("acc_ix1", 8'h11, acc_out)
		step(13'h005);
		`CHK("ea_ix", 13'h0FF, effective_addr_out)
		`CHK("acc_ix", 8'h22, acc_out)
		step(13'h007);
		`CHK("ea_dir", 13'h040, effective_addr_out)
		`CHK("acc_dir", 8'h33, acc_out)
		step(13'h00A);
		`CHK("ea_ext", 13'h1234, effective_addr_out)
		`CHK("acc_ext", 8'h44, acc_out)
		step(13'h00D);
		`CHK("ea_ix2", 13'h10FF, effective_addr_out)
		`CHK("acc_ix2", 8'h55, acc_out)
		$display("test modes done");
	endtask : t_modes

	task automatic t_rmw();
		int w;
		prog(13'h000, '{8'hA6, 8'h5A, 8'hB7, 8'h60, 8'h3C, 8'h60,
			8'h3D, 8'h60, 8'h97, 8'h99, 8'h9A, 8'hA6, 8'h03, 8'h42,
			8'hA7, 8'h00, 8'h40});
		start();
		step(13'h002);
		step(13'h004);
		`CHK("store", 8'h5A, mem_u.mem[13'h060])
		step(13'h006);
		`CHK("inc", 8'h5B, mem_u.mem[13'h060])
		w = n_wr;
		step(13'h008);
		`CHK("tst_nowr", w, n_wr)
		`CHK("tst_z", 1'b0, condition_code_out[CC_Z])
		step(13'h009);
		`CHK("tax", 8'h5A, index_out)
		`CHK("cls_ctrl", CL_CTRL, instr_class_out)
		step(13'h00A);
		step(13'h00B);
		`CHK("sec_cli", 5'h01, condition_code_out)
		step(13'h00D);
		step(13'h00E);
		`CHK("mul_lo", 8'h0E, acc_out)
		`CHK("mul_hi", 8'h01, index_out)
		step(13'h010);
		`CHK("imm_store_nop", 8'h01, index_out)
		step(13'h011);
		`CHK("neg", 8'hF2, acc_out)
		`CHK("neg_c", 1'b1, condition_code_out[CC_C])
		$display("test rmw done");
	endtask : t_rmw

	task automatic t_branch();
		prog(13'h000, '{8'hCC, 8'h01, 8'h00});
		prog(13'h100, '{8'h2D, 8'h7F});
		prog(13'h181, '{8'h2C, 8'h00, 8'h2F, 8'h80});
		prog(13'h105, '{8'h2E, 8'h10, 8'h2E, 8'h20});
		irq_line_in = 1'b1;
		start();
		step(13'h100);
		step(13'h181);
		step(13'h183);
		`CHK("cls_branch", CL_BRANCH, instr_class_out)
		step(13'h105);
		step(13'h107);
		irq_line_in = 1'b0;
		step(13'h129);
		$display("test branch done");
	endtask : t_branch

	task automatic t_bits();
		prog(13'h000, '{8'h16, 8'h50, 8'h06, 8'h50, 8'h10});
		prog(13'h015, '{8'h07, 8'h50, 8'h10, 8'h17, 8'h50,
			8'h07, 8'h50, 8'hF0});
		prog(13'h050, '{8'h00});
		start();
		step(13'h002);
		`CHK("cls_bit", CL_BIT, instr_class_out)
		`CHK("bset", 8'h08, mem_u.mem[13'h050])
		step(13'h015);
		`CHK("brset_c", 1'b1, condition_code_out[CC_C])
		step(13'h018);
		`CHK("brclr_c", 1'b1, condition_code_out[CC_C])
		step(13'h01A);
		`CHK("bclr", 8'h00, mem_u.mem[13'h050])
		step(13'h00D);
		`CHK("brclr_c0", 1'b0, condition_code_out[CC_C])
		$display("test bits done");
	endtask : t_bits

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		for (int i = 0; i < 8192; i++)
			mem_u.mem[i] = 8'h00;
		repeat (6) @(posedge mclk_in);
		t_arith();
		t_modes();
		t_rmw();
		t_branch();
		t_bits();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
